// File: design/ddr2_timing_regs.vh
`ifndef DDR2_TIMING_REGS_VH
`define DDR2_TIMING_REGS_VH

// clock period at 10 MHz
`define TCK_PS 32'd100000

// command codes on the user port
`define CMD_NOP 4'h0
`define CMD_ACT 4'h1
`define CMD_RD 4'h2
`define CMD_WR 4'h3
`define CMD_WRA 4'h4
`define CMD_PRE 4'h5
`define CMD_REF 4'h6
`define CMD_MRS 4'h7
`define CMD_PDE 4'h8
`define CMD_PDX 4'h9
`define CMD_SRE 4'ha
`define CMD_SRX 4'hb

// pin encodings {ras_n, cas_n, we_n}
`define PINS_NOP 3'h7
`define PINS_ACT 3'h3
`define PINS_RD 3'h5
`define PINS_WR 3'h4
`define PINS_PRE 3'h2
`define PINS_REF 3'h1
`define PINS_MRS 3'h0

// auto precharge flag position on the address pins
`define AUTO_PRE_BIT 10

// four_activate_window in ps
`define FAW_1K_800_PS 32'd35000
`define FAW_1K_667_PS 32'd37500
`define FAW_2K_800_PS 32'd45000
`define FAW_2K_667_PS 32'd50000

// other times in ps
`define WR_RECOVERY_PS 32'd15000
`define WRITE_TO_READ_PS 32'd7500
`define READ_TO_PRE_PS 32'd7500
`define SR_EXIT_EXTRA_PS 32'd10000
`define TIS_PS 32'd200
`define TIH_PS 32'd275

// times in clock cycles
`define COLUMN_TO_COLUMN_CYC 8'h02
`define SR_EXIT_READ_CYC 8'hc8
`define PPD_EXIT_CYC 8'h02
`define APD_FAST_EXIT_CYC 8'h02
`define APD_SLOW_800_CYC 8'h08
`define APD_SLOW_667_CYC 8'h07
`define CKE_PULSE_CYC 8'h03
`define ODT_TO_PD_CYC 8'h03
`define PD_EXIT_ODT_CYC 8'h08

`define NUM_BANKS 8
`define NUM_FAW_SLOTS 4

`endif

// File: design/spacing_timer.v
`timescale 1ns/1ps
// down-counter that reports when a spacing has elapsed
module spacing_timer (
    // clock and reset
    input wire clk,
    input wire rstn,
    // load
    input wire load,
    input wire [7:0] value,
    // status
    output wire done
);
    reg [7:0] count_q;
    reg [7:0] count_d;

    always @* begin
        count_d = count_q;
        if (load) begin
            count_d = value;
        end else if (count_q != 8'h00) begin
            count_d = count_q - 8'h01;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_q <= 8'h00;
        end else begin
            count_q <= count_d;
        end
    end

    assign done = (count_q == 8'h00);
endmodule

// File: design/ddr2_command_spacing_timer.v
`timescale 1ns/1ps
`include "ddr2_timing_regs.vh"

module ddr2_command_spacing_timer #(
    parameter [31:0] TRFC_PS = 32'd127500,
    parameter [31:0] TRP_PS = 32'd15000
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // configuration
    input wire grade_800,
    input wire page_2k,
    input wire slow_exit,
    input wire [2:0] additive_latency,
    // command request
    input wire cmd_valid,
    input wire [3:0] cmd_code,
    input wire [2:0] cmd_bank,
    input wire [13:0] cmd_addr,
    output wire cmd_ready,
    // termination request
    input wire odt_req,
    // dram pins
    output reg ck_en_q,
    output reg cke_q,
    output reg cs_n_q,
    output reg ras_n_q,
    output reg cas_n_q,
    output reg we_n_q,
    output reg [2:0] ba_q,
    output reg [13:0] addr_q,
    output reg odt_q
);
    localparam [1:0] ST_RUN = 2'h0;
    localparam [1:0] ST_PPD = 2'h1;
    localparam [1:0] ST_APD = 2'h2;
    localparam [1:0] ST_SR = 2'h3;

    // ceiling of a time over the clock period, never below one cycle
    function [7:0] cyc;
        input [31:0] ps;
        reg [31:0] c;
        begin
            c = (ps + `TCK_PS - 32'd1) / `TCK_PS;
            if (c == 32'd0) begin
                c = 32'd1;
            end
            cyc = c[7:0];
        end
    endfunction

    reg [1:0] state_q;
    reg [`NUM_BANKS-1:0] open_q;
    reg [7:0] dal_q [0:`NUM_BANKS-1];
    reg [7:0] rtp_q [0:`NUM_BANKS-1];
    reg [7:0] faw_q [0:`NUM_FAW_SLOTS-1];
    reg [7:0] hold_q;

    wire issue = cmd_valid & cmd_ready;
    wire ccd_done;
    wire wtr_done;
    wire nonread_done;
    wire read_done;
    wire cke_done;
    wire odt_settle_done;
    wire odt_lock_done;

    reg [7:0] faw_cyc;
    reg [7:0] slow_cyc;
    reg [7:0] exit_nonread;
    reg [7:0] exit_read;
    reg faw_free;
    reg [1:0] faw_slot;
    reg allow;
    integer i;
    integer j;

    wire col_cmd = (cmd_code == `CMD_RD) | (cmd_code == `CMD_WR) | (cmd_code == `CMD_WRA);
    wire wr_cmd = (cmd_code == `CMD_WR) | (cmd_code == `CMD_WRA);
    wire cke_cmd = (cmd_code == `CMD_PDE) | (cmd_code == `CMD_PDX) |
                   (cmd_code == `CMD_SRE) | (cmd_code == `CMD_SRX);
    wire odt_change = (odt_req != odt_q) & odt_lock_done & (state_q == ST_RUN);

    always @* begin
        if (page_2k) begin
            faw_cyc = grade_800 ? cyc(`FAW_2K_800_PS) : cyc(`FAW_2K_667_PS);
        end else begin
            faw_cyc = grade_800 ? cyc(`FAW_1K_800_PS) : cyc(`FAW_1K_667_PS);
        end
        slow_cyc = (grade_800 ? `APD_SLOW_800_CYC : `APD_SLOW_667_CYC) - {5'h00, additive_latency};
        if (slow_cyc == 8'h00 || slow_cyc > `APD_SLOW_800_CYC) begin
            slow_cyc = 8'h01;
        end
        faw_free = 1'b0;
        faw_slot = 2'h0;
        for (j = `NUM_FAW_SLOTS - 1; j >= 0; j = j - 1) begin
            if (faw_q[j] == 8'h00) begin
                faw_free = 1'b1;
                faw_slot = j[1:0];
            end
        end
        exit_nonread = `PPD_EXIT_CYC;
        exit_read = `PPD_EXIT_CYC;
        if (state_q == ST_SR) begin
            exit_nonread = cyc(TRFC_PS + `SR_EXIT_EXTRA_PS);
            exit_read = `SR_EXIT_READ_CYC;
        end else if (state_q == ST_APD) begin
            exit_read = slow_exit ? slow_cyc : `APD_FAST_EXIT_CYC;
        end else begin
            exit_nonread = `PPD_EXIT_CYC;
        end
    end

    always @* begin
        allow = 1'b0;
        if (state_q == ST_RUN) begin
            case (cmd_code)
                `CMD_NOP: allow = 1'b1;
                `CMD_ACT: allow = nonread_done & faw_free & (dal_q[cmd_bank] == 8'h00) & ~open_q[cmd_bank];
                `CMD_RD: allow = read_done & ccd_done & wtr_done & open_q[cmd_bank];
                `CMD_WR: allow = nonread_done & ccd_done & open_q[cmd_bank];
                `CMD_WRA: allow = nonread_done & ccd_done & open_q[cmd_bank];
                `CMD_PRE: allow = nonread_done & (rtp_q[cmd_bank] == 8'h00);
                `CMD_REF: allow = nonread_done & (open_q == {`NUM_BANKS{1'b0}});
                `CMD_MRS: allow = nonread_done & (open_q == {`NUM_BANKS{1'b0}});
                `CMD_PDE: allow = nonread_done & cke_done & odt_settle_done & ~odt_change;
                `CMD_SRE: allow = nonread_done & cke_done & odt_settle_done & ~odt_change &
                                  (open_q == {`NUM_BANKS{1'b0}});
                default: allow = 1'b0;
            endcase
        end else if (state_q == ST_SR) begin
            allow = (cmd_code == `CMD_SRX) & cke_done & ck_en_q;
        end else begin
            allow = (cmd_code == `CMD_PDX) & cke_done;
        end
    end

    assign cmd_ready = allow;

    spacing_timer ccd_timer (.clk(clk), .rstn(rstn), .load(issue & col_cmd),
        .value(`COLUMN_TO_COLUMN_CYC), .done(ccd_done));
    spacing_timer wtr_timer (.clk(clk), .rstn(rstn), .load(issue & wr_cmd),
        .value(cyc(`WRITE_TO_READ_PS)), .done(wtr_done));
    spacing_timer nonread_timer (.clk(clk), .rstn(rstn),
        .load(issue & ((cmd_code == `CMD_PDX) | (cmd_code == `CMD_SRX))),
        .value(exit_nonread), .done(nonread_done));
    spacing_timer read_timer (.clk(clk), .rstn(rstn),
        .load(issue & ((cmd_code == `CMD_PDX) | (cmd_code == `CMD_SRX))),
        .value(exit_read), .done(read_done));
    spacing_timer cke_timer (.clk(clk), .rstn(rstn), .load(issue & cke_cmd),
        .value(`CKE_PULSE_CYC), .done(cke_done));
    spacing_timer odt_settle_timer (.clk(clk), .rstn(rstn), .load(odt_change),
        .value(`ODT_TO_PD_CYC), .done(odt_settle_done));
    spacing_timer odt_lock_timer (.clk(clk), .rstn(rstn),
        .load(issue & ((cmd_code == `CMD_PDX) | (cmd_code == `CMD_SRX))),
        .value(`PD_EXIT_ODT_CYC), .done(odt_lock_done));

    // bank bookkeeping, activate window slots and power state
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_RUN;
            open_q <= {`NUM_BANKS{1'b0}};
            hold_q <= 8'h00;
            for (i = 0; i < `NUM_BANKS; i = i + 1) begin
                dal_q[i] <= 8'h00;
                rtp_q[i] <= 8'h00;
            end
            for (i = 0; i < `NUM_FAW_SLOTS; i = i + 1) begin
                faw_q[i] <= 8'h00;
            end
        end else begin
            for (i = 0; i < `NUM_BANKS; i = i + 1) begin
                if (dal_q[i] != 8'h00) begin
                    dal_q[i] <= dal_q[i] - 8'h01;
                end
                if (rtp_q[i] != 8'h00) begin
                    rtp_q[i] <= rtp_q[i] - 8'h01;
                end
            end
            for (i = 0; i < `NUM_FAW_SLOTS; i = i + 1) begin
                if (faw_q[i] != 8'h00) begin
                    faw_q[i] <= faw_q[i] - 8'h01;
                end
            end
            if (hold_q != 8'h00) begin
                hold_q <= hold_q - 8'h01;
            end
            if (issue) begin
                case (cmd_code)
                    `CMD_ACT: begin
                        open_q[cmd_bank] <= 1'b1;
                        faw_q[faw_slot] <= faw_cyc;
                    end
                    `CMD_RD: rtp_q[cmd_bank] <= cyc(`READ_TO_PRE_PS);
                    `CMD_WRA: begin
                        open_q[cmd_bank] <= 1'b0;
                        dal_q[cmd_bank] <= cyc(`WR_RECOVERY_PS) + cyc(TRP_PS);
                    end
                    `CMD_PRE: open_q[cmd_bank] <= 1'b0;
                    `CMD_PDE: state_q <= (open_q != {`NUM_BANKS{1'b0}}) ? ST_APD : ST_PPD;
                    `CMD_SRE: begin
                        state_q <= ST_SR;
                        hold_q <= cyc(`TIS_PS) + cyc(`TCK_PS) + cyc(`TIH_PS);
                    end
                    `CMD_PDX: state_q <= ST_RUN;
                    `CMD_SRX: state_q <= ST_RUN;
                    default: state_q <= state_q;
                endcase
            end
        end
    end

    // pin drive
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ck_en_q <= 1'b1;
            cke_q <= 1'b1;
            cs_n_q <= 1'b1;
            ras_n_q <= 1'b1;
            cas_n_q <= 1'b1;
            we_n_q <= 1'b1;
            ba_q <= 3'h0;
            addr_q <= 14'h0000;
            odt_q <= 1'b0;
        end else begin
            cs_n_q <= 1'b1;
            {ras_n_q, cas_n_q, we_n_q} <= `PINS_NOP;
            if (odt_change) begin
                odt_q <= odt_req;
            end
            if (state_q == ST_SR && hold_q == 8'h00 && !(cmd_valid && cmd_code == `CMD_SRX)) begin
                ck_en_q <= 1'b0;
            end else if (cmd_valid && cmd_code == `CMD_SRX) begin
                ck_en_q <= 1'b1;
            end
            if (issue) begin
                ba_q <= cmd_bank;
                addr_q <= cmd_addr;
                case (cmd_code)
                    `CMD_ACT: begin
                        cs_n_q <= 1'b0;
                        {ras_n_q, cas_n_q, we_n_q} <= `PINS_ACT;
                    end
                    `CMD_RD: begin
                        cs_n_q <= 1'b0;
                        {ras_n_q, cas_n_q, we_n_q} <= `PINS_RD;
                    end
                    `CMD_WR: begin
                        cs_n_q <= 1'b0;
                        {ras_n_q, cas_n_q, we_n_q} <= `PINS_WR;
                        addr_q[`AUTO_PRE_BIT] <= 1'b0;
                    end
                    `CMD_WRA: begin
                        cs_n_q <= 1'b0;
                        {ras_n_q, cas_n_q, we_n_q} <= `PINS_WR;
                        addr_q[`AUTO_PRE_BIT] <= 1'b1;
                    end
                    `CMD_PRE: begin
                        cs_n_q <= 1'b0;
                        {ras_n_q, cas_n_q, we_n_q} <= `PINS_PRE;
                        addr_q[`AUTO_PRE_BIT] <= 1'b0;
                    end
                    `CMD_REF: begin
                        cs_n_q <= 1'b0;
                        {ras_n_q, cas_n_q, we_n_q} <= `PINS_REF;
                    end
                    `CMD_MRS: begin
                        cs_n_q <= 1'b0;
                        {ras_n_q, cas_n_q, we_n_q} <= `PINS_MRS;
                    end
                    `CMD_PDE: cke_q <= 1'b0;
                    `CMD_SRE: begin
                        cke_q <= 1'b0;
                        cs_n_q <= 1'b0;
                        {ras_n_q, cas_n_q, we_n_q} <= `PINS_REF;
                    end
                    `CMD_PDX: cke_q <= 1'b1;
                    `CMD_SRX: cke_q <= 1'b1;
                    default: cs_n_q <= 1'b1;
                endcase
            end
        end
    end
endmodule

// File: verification/spacing_checker.sv
`timescale 1ns/1ps
module spacing_checker #(
    parameter [31:0] TRFC_PS = 32'd127500
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // configuration
    input wire grade_800,
    input wire slow_exit,
    input wire [2:0] additive_latency,
    // dram pins
    input wire ck_en_q,
    input wire cke_q,
    input wire cs_n_q,
    input wire ras_n_q,
    input wire cas_n_q,
    input wire we_n_q,
    input wire [2:0] ba_q,
    input wire [13:0] addr_q,
    input wire odt_q
);
    localparam int XSNR = (TRFC_PS + 32'd109999) / 32'd100000;
    wire col = !cs_n_q && ras_n_q && !cas_n_q;
    wire rd = col && we_n_q;
    wire wra = col && !we_n_q && addr_q[10];
    wire act = !cs_n_q && !ras_n_q && cas_n_q && we_n_q;
    wire [3:0] slow = (grade_800 ? 4'h8 : 4'h7) - {1'b0, additive_latency};
    wire [7:0] rd_need = !slow_exit ? 8'h02 : (slow == 4'h0) ? 8'h01 : {4'h0, slow};
    reg sr_q;
    reg [7:0] since_q;
    reg [7:0] odt_age_q;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sr_q <= 1'b0;
            since_q <= 8'hff;
            odt_age_q <= 8'hff;
        end else begin
            if ($fell(cke_q))
                sr_q <= !cs_n_q;
            since_q <= !cke_q ? 8'h00 : (since_q == 8'hff) ? since_q : since_q + 8'h01;
            odt_age_q <= $changed(odt_q) ? 8'h00 : (odt_age_q == 8'hff) ? odt_age_q : odt_age_q + 8'h01;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_hold3;
        ck_en_q [*3];
    endsequence
    sequence s_cke_steady;
        $stable(cke_q) [*2];
    endsequence
    property p_ccd; col |=> !col; endproperty
    property p_wra_act; wra |=> !(act && ba_q == $past(ba_q)); endproperty
    property p_xsnr; !cs_n_q && !rd && cke_q && sr_q |-> since_q >= XSNR; endproperty
    property p_xsrd; rd && sr_q |-> since_q >= 8'd200; endproperty
    property p_xp; $rose(cke_q) |=> cs_n_q; endproperty
    property p_xard; rd && !sr_q |-> since_q >= rd_need; endproperty
    property p_cke; $changed(cke_q) |=> s_cke_steady; endproperty
    property p_anpd; $fell(cke_q) |-> odt_age_q >= 8'd2; endproperty
    property p_axpd; $changed(odt_q) |-> since_q >= 8'd8; endproperty
    property p_clk_hold; $fell(cke_q) |-> s_hold3; endproperty
    a_ccd: assert property (p_ccd) else $error("column commands too close");
    a_wra_act: assert property (p_wra_act) else $error("activate too soon after auto precharge write");
    a_xsnr: assert property (p_xsnr) else $error("command too soon after self refresh exit");
    a_xsrd: assert property (p_xsrd) else $error("read too soon after self refresh exit");
    a_xp: assert property (p_xp) else $error("command too soon after power-down exit");
    a_xard: assert property (p_xard) else $error("read too soon after active power-down exit");
    a_cke: assert property (p_cke) else $error("clock enable pulse too short");
    a_anpd: assert property (p_anpd) else $error("termination changed too close to power-down");
    a_axpd: assert property (p_axpd) else $error("termination changed too soon after exit");
    a_clk_hold: assert property (p_clk_hold) else $error("clock stopped too soon");
endmodule

bind ddr2_command_spacing_timer spacing_checker #(.TRFC_PS(TRFC_PS)) chk (
    .clk(clk),
    .rstn(rstn),
    .grade_800(grade_800),
    .slow_exit(slow_exit),
    .additive_latency(additive_latency),
    .ck_en_q(ck_en_q),
    .cke_q(cke_q),
    .cs_n_q(cs_n_q),
    .ras_n_q(ras_n_q),
    .cas_n_q(cas_n_q),
    .we_n_q(we_n_q),
    .ba_q(ba_q),
    .addr_q(addr_q),
    .odt_q(odt_q)
);

// File: verification/dram_model.sv
`timescale 1ns/1ps
module dram_model (
    // clock and reset
    input wire clk,
    input wire rstn,
    // pins
    input wire cke,
    input wire cs_n,
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    input wire [2:0] ba,
    input wire [13:0] addr,
    input wire odt,
    // status
    output wire term_on,
    output reg [7:0] act_count
);
    reg [1:0] odt_pipe_q;
    reg off_q;
    reg slow_mode_q;
    reg strobe_diff_q;
    reg drive_q;
    wire mrs = cke && !cs_n && !ras_n && !cas_n && !we_n;
    assign term_on = odt_pipe_q[1] | off_q;
    always @(negedge clk) begin
        off_q <= odt_pipe_q[1];
    end
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            odt_pipe_q <= 2'h0;
            act_count <= 8'h00;
            slow_mode_q <= 1'b0;
            strobe_diff_q <= 1'b1;
            drive_q <= 1'b0;
        end else begin
            odt_pipe_q <= {odt_pipe_q[0], odt};
            if (cke && !cs_n && !ras_n && cas_n && we_n)
                act_count <= act_count + 8'h01;
            if (mrs && ba == 3'h0)
                slow_mode_q <= addr[12];
            if (mrs && ba == 3'h1) begin
                strobe_diff_q <= !addr[10];
                drive_q <= addr[7];
            end
        end
    end
endmodule

// File: verification/ddr2_command_spacing_timer_bench.sv
`timescale 1ns/1ps
`include "ddr2_timing_regs.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module ddr2_command_spacing_timer_bench;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg grade_800 = 1'b1;
    reg page_2k = 1'b0;
    reg slow_exit = 1'b1;
    reg [2:0] additive_latency = 3'h2;
    reg cmd_valid = 1'b0;
    reg [3:0] cmd_code = 4'h0;
    reg [2:0] cmd_bank = 3'h0;
    reg [13:0] cmd_addr = 14'h0000;
    reg odt_req = 1'b0;
    wire cmd_ready, ck_en_q, cke_q, cs_n_q, ras_n_q, cas_n_q, we_n_q, odt_q, term_on;
    wire [2:0] ba_q;
    wire [13:0] addr_q;
    wire [7:0] act_count;
    integer err_count = 0;
    integer total_checks = 0;
    integer cyc = 0;
    integer at = 0;
    integer prev = 0;
    integer mark, i;
    reg [10:0] rows [0:9];
    ddr2_command_spacing_timer uut (.clk(clk), .rstn(rstn), .grade_800(grade_800), .page_2k(page_2k),
        .slow_exit(slow_exit), .additive_latency(additive_latency), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready),
        .odt_req(odt_req), .ck_en_q(ck_en_q), .cke_q(cke_q), .cs_n_q(cs_n_q), .ras_n_q(ras_n_q),
        .cas_n_q(cas_n_q), .we_n_q(we_n_q), .ba_q(ba_q), .addr_q(addr_q), .odt_q(odt_q));
    dram_model dev (.clk(clk), .rstn(rstn), .cke(cke_q), .cs_n(cs_n_q), .ras_n(ras_n_q),
        .cas_n(cas_n_q), .we_n(we_n_q), .ba(ba_q), .addr(addr_q), .odt(odt_q),
        .term_on(term_on), .act_count(act_count));
    always #50 clk = ~clk;
    task tally_and_finish;
        begin
            $display("checks %0d errors %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_count = err_count + 1;
            tally_and_finish;
        end
    end
    task tick;
        begin
            @(posedge clk);
            #10;
        end
    endtask
    task issue(input [3:0] c, input [2:0] b, input [13:0] a);
        integer n;
        begin
            cmd_code = c;
            cmd_bank = b;
            cmd_addr = a;
            cmd_valid = 1'b1;
            n = 0;
            @(negedge clk);
            while (cmd_ready !== 1'b1 && n < 300) begin
                n = n + 1;
                @(negedge clk);
            end
            tick;
            prev = at;
            at = cyc;
            if (n == 300) `CHK("ready", 1'b1, 1'b0)
        end
    endtask
    initial begin
        // code, bank, mode bit 12, expected {ras_n, cas_n, we_n}
        rows[0] = {`CMD_ACT, 3'h0, 1'b0, `PINS_ACT};
        rows[1] = {`CMD_RD, 3'h0, 1'b0, `PINS_RD};
        rows[2] = {`CMD_WR, 3'h0, 1'b0, `PINS_WR};
        rows[3] = {`CMD_PRE, 3'h0, 1'b0, `PINS_PRE};
        rows[4] = {`CMD_ACT, 3'h1, 1'b0, `PINS_ACT};
        rows[5] = {`CMD_WRA, 3'h1, 1'b0, `PINS_WR};
        rows[6] = {`CMD_ACT, 3'h1, 1'b0, `PINS_ACT};
        rows[7] = {`CMD_PRE, 3'h1, 1'b0, `PINS_PRE};
        rows[8] = {`CMD_REF, 3'h0, 1'b0, `PINS_REF};
        rows[9] = {`CMD_MRS, 3'h0, 1'b1, `PINS_MRS};
        repeat (10) @(posedge clk);
        `CHK("reset_pins", 7'h7e, {ck_en_q, cke_q, cs_n_q, ras_n_q, cas_n_q, we_n_q, odt_q})
        #10;
        rstn = 1'b1;
        for (i = 0; i < 10; i = i + 1) begin
            issue(rows[i][10:7], rows[i][6:4], {1'b0, rows[i][3], 12'h000});
            `CHK("pins", {1'b0, rows[i][2:0]}, {cs_n_q, ras_n_q, cas_n_q, we_n_q})
            `CHK("bank", rows[i][6:4], ba_q)
            `CHK("addr", ({1'b0, rows[i][3], 1'b0, (rows[i][10:7] == `CMD_WRA), 10'h000}), addr_q)
            if (i == 2) `CHK("rd_wr_gap", 1'b1, at - prev >= 2)
            if (i == 6) `CHK("wra_act_gap", 1'b1, at - prev >= 2)
        end
        issue(`CMD_ACT, 3'h2, 14'h0000);
        issue(`CMD_RD, 3'h2, 14'h0000);
        issue(`CMD_RD, 3'h2, 14'h0000);
        `CHK("rd_rd_gap", 1'b1, at - prev >= 2)
        cmd_code = 4'hf;
        cmd_valid = 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            tick;
            `CHK("unknown_refused", 2'h1, {cmd_ready, cs_n_q})
        end
        issue(`CMD_PDE, 3'h0, 14'h0000);
        `CHK("apd_cke", 1'b0, cke_q)
        issue(`CMD_PDX, 3'h0, 14'h0000);
        `CHK("cke_low_width", 1'b1, at - prev >= 3)
        issue(`CMD_RD, 3'h2, 14'h0000);
        `CHK("slow_exit_rd", 1'b1, at - prev >= 6)
        issue(`CMD_PRE, 3'h2, 14'h0000);
        slow_exit = 1'b0;
        issue(`CMD_ACT, 3'h3, 14'h0000);
        issue(`CMD_PDE, 3'h0, 14'h0000);
        issue(`CMD_PDX, 3'h0, 14'h0000);
        issue(`CMD_RD, 3'h3, 14'h0000);
        `CHK("fast_exit_rd", 1'b1, at - prev >= 2)
        issue(`CMD_PRE, 3'h3, 14'h0000);
        grade_800 = 1'b0;
        page_2k = 1'b1;
        slow_exit = 1'b1;
        issue(`CMD_ACT, 3'h5, 14'h0000);
        issue(`CMD_PDE, 3'h0, 14'h0000);
        issue(`CMD_PDX, 3'h0, 14'h0000);
        issue(`CMD_RD, 3'h5, 14'h0000);
        `CHK("slow_exit_667_rd", 1'b1, at - prev >= 5)
        issue(`CMD_PRE, 3'h5, 14'h0000);
        issue(`CMD_PDE, 3'h0, 14'h0000);
        issue(`CMD_PDX, 3'h0, 14'h0000);
        cmd_valid = 1'b0;
        odt_req = 1'b1;
        tick;
        `CHK("odt_locked", 1'b0, odt_q)
        issue(`CMD_ACT, 3'h4, 14'h0000);
        `CHK("ppd_exit_gap", 1'b1, at - prev >= 2)
        issue(`CMD_PRE, 3'h4, 14'h0000);
        cmd_valid = 1'b0;
        repeat (8) tick;
        `CHK("odt_on", 2'h3, {odt_q, term_on})
        issue(`CMD_SRE, 3'h0, 14'h0000);
        `CHK("sr_cke", 1'b0, cke_q)
        repeat (4) tick;
        `CHK("clock_stopped", 1'b0, ck_en_q)
        issue(`CMD_SRX, 3'h0, 14'h0000);
        mark = at;
        `CHK("sr_exit_pins", 2'h3, {ck_en_q, cke_q})
        issue(`CMD_ACT, 3'h0, 14'h0000);
        `CHK("xsnr_gap", 1'b1, at - prev >= 2)
        issue(`CMD_RD, 3'h0, 14'h0000);
        `CHK("xsrd_gap", 1'b1, at - mark >= 200)
        issue(`CMD_PRE, 3'h0, 14'h0000);
        `CHK("act_total", 8'd8, act_count)
        tally_and_finish;
    end
endmodule
